//--- pkg/rmc_pkg.sv
`default_nettype none
package rmc_pkg;
  // clock and time bases
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned POLL_WAKE_MS = 30;
  localparam int unsigned ASSOC_WAKE_MS = 750;
  localparam int unsigned POLL_WAKE_CYC = POLL_WAKE_MS * CYC_PER_MS;
  localparam int unsigned ASSOC_WAKE_CYC = ASSOC_WAKE_MS * CYC_PER_MS;
  localparam int unsigned RETRY_MIN_MS = 1;
  localparam int unsigned RETRY_MAX_MS = 48;
  localparam int unsigned BACKOFF_PERIOD_US = 320;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned BACKOFF_CYC = BACKOFF_PERIOD_US * (CLK_HZ / US_PER_S);
  localparam int unsigned CHAR_US = 1042;
  localparam int unsigned CHAR_CYC = CHAR_US * (CLK_HZ / US_PER_S);

  // widths and counts
  localparam int unsigned TW = 32;
  localparam int unsigned NSLOT = 4;
  localparam logic [2:0] CCA_CYCLES = 3'h5;
  localparam logic [1:0] CCA_RETRIES = 2'h2;
  localparam logic [3:0] BE_MAX = 4'h8;

  // register map (byte offsets)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SLEEP_PERIOD = 8'h04;
  localparam logic [7:0] A_AWAKE_HOLD = 8'h08;
  localparam logic [7:0] A_ASSOC_FLAGS = 8'h0C;
  localparam logic [7:0] A_SLEEP_OPT = 8'h10;
  localparam logic [7:0] A_ENERGY_LVL = 8'h14;
  localparam logic [7:0] A_BACKOFF_MIN = 8'h18;
  localparam logic [7:0] A_MAC_MODE = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_ASSOC_CODE = 8'h24;
  localparam logic [7:0] A_FAIL_COUNT = 8'h28;

  // control register fields, association flag and sleep option bits
  localparam int unsigned C_COORD = 0;
  localparam int unsigned C_FRAMED = 1;
  localparam int unsigned C_MODE_LO = 2;
  localparam int unsigned C_MODE_HI = 4;
  localparam int unsigned F_POLL_PIN = 3;
  localparam int unsigned O_NO_POLL = 0;

  localparam logic [2:0] SM_PIN = 3'h1;
  localparam logic [2:0] SM_CYCLIC = 3'h4;
  localparam logic [2:0] SM_CYCLIC_PIN = 3'h5;

  // status message types
  localparam logic [7:0] ST_HW_RESET = 8'h00;
  localparam logic [7:0] ST_WDT_RESET = 8'h01;
  localparam logic [7:0] ST_ASSOC = 8'h02;
  localparam logic [7:0] ST_DISASSOC = 8'h03;
  localparam logic [7:0] ST_FORMED = 8'h06;
  localparam logic [7:0] ST_OVERVOLT = 8'h0D;

  // association codes
  localparam logic [7:0] AC_OK = 8'h00;
  localparam logic [7:0] AC_NO_JOIN = 8'h03;
  localparam logic [7:0] AC_BEACON = 8'h04;
  localparam logic [7:0] AC_PAN_MISMATCH = 8'h05;
  localparam logic [7:0] AC_CH_MISMATCH = 8'h06;
  localparam logic [7:0] AC_NO_RESP = 8'h0C;
  localparam logic [7:0] AC_DISASSOC = 8'h13;
  localparam logic [7:0] AC_INIT = 8'hFF;

  // association events from the network layer
  typedef enum logic [3:0] {
    RMC_EV_NONE = 4'h0,
    RMC_EV_COORD_UP = 4'h1,
    RMC_EV_ASSOC = 4'h2,
    RMC_EV_PEER = 4'h3,
    RMC_EV_NO_JOIN = 4'h4,
    RMC_EV_BEACON = 4'h5,
    RMC_EV_PAN_MISMATCH = 4'h6,
    RMC_EV_CH_MISMATCH = 4'h7,
    RMC_EV_NO_RESP = 4'h8,
    RMC_EV_DISASSOC = 4'h9,
    RMC_EV_FORM_FAIL = 4'hA
  } rmc_ev_t;

  typedef enum logic [2:0] {
    RMC_TX_IDLE = 3'h0,
    RMC_TX_BACKOFF = 3'h1,
    RMC_TX_ASSESS = 3'h2,
    RMC_TX_RETRY_WAIT = 3'h3,
    RMC_TX_SEND = 3'h4
  } rmc_tx_t;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } rmc_bus_t;

  // outgoing frame request from the stack
  typedef struct packed {
    logic valid;
    logic [15:0] dest;
    logic bcast;
    logic [2:0] retries;
  } rmc_frame_t;

  // frame dispatch result
  typedef struct packed {
    logic send;
    logic held;
    logic fail;
    logic [15:0] dest;
  } rmc_txres_t;

  // status message out
  typedef struct packed {
    logic valid;
    logic [7:0] kind;
  } rmc_msg_t;

  // per-address hold slot
  typedef struct packed {
    logic used;
    logic pending;
    logic [15:0] addr;
    logic [TW-1:0] hold_cnt;
    logic [TW-1:0] awake_cnt;
  } rmc_slot_t;
endpackage
`default_nettype wire

//--- src/rmc_ctrl.sv
// Behaviour
// - indirect delivery only with nonzero sleep period
// - held message sent on poll, dropped at 2.5x timeout
// - after indirect send, direct for awake hold
// - awake hold expiry returns address to holding
// - cyclic sleeper polls each wake unless option bit0
// - pin sleeper polls on wake if flag bit3
// - exit poll waits for command mode end, apply
// - framed mode emits status; query returns code
// - status 02 assoc, 03 disassoc, 06 formed
// - status 00, 01, 0D; overvoltage blocks transmit except held sends on poll
// - code FF until known, 00 when up
// - scan codes 03, 04, 05
// - association codes 06, 0C, 13
// - no sleep in command or config work
// - no sleep with serial output unless RTS held
// - pin sleep stays awake one character
// - cyclic minimum wake: hold, 30 ms, 750 ms
// - new data extends wake by awake hold
// - no pin-mode sleep without pin request; no sleep with pending tx
// - energy above level withholds transmission except held sends on poll
// - random backoff from min exponent; zero is immediate
// - two extra tries after assessment failure in mac mode 0, for broadcasts or frames with zero retries
// - backoff 0..2^n-1 periods, n grows per failure
// - five failures: retry 1-48 ms, then error
// - fail count saturates, clears on zero write
`default_nettype none
module rmc_ctrl (
  input wire logic i_clk, // 20 MHz clock
  input wire logic i_rst_b, // async reset, active low
  input wire rmc_pkg::rmc_bus_t i_bus, // register access
  output logic [31:0] o_rdata, // read data, cycle after strobe
  input wire rmc_pkg::rmc_frame_t i_frame, // frame to send
  output logic o_frame_ready, // ready for a frame (sequencer idle)
  input wire logic i_poll_rx, // poll received from i_poll_addr
  input wire logic [15:0] i_poll_addr, // polling address
  input wire logic i_traffic, // rx/tx activity with i_traffic_addr
  input wire logic [15:0] i_traffic_addr, // activity address
  output rmc_pkg::rmc_txres_t o_txres, // dispatch result, one cycle
  input wire logic [7:0] i_energy, // measured channel energy
  input wire logic i_wake, // device woke (timer)
  input wire logic i_pin_wake, // device woke by pin
  input wire logic i_cmd_mode, // command mode or escape in progress
  input wire logic i_cfg_busy, // local/remote config processing
  input wire logic i_cfg_applied, // pending changes applied pulse
  input wire logic i_exit_poll_req, // poll requested for cmd exit
  input wire logic i_ser_pending, // data queued to serial port
  input wire logic i_rts_hold, // serial out held by RTS
  input wire logic i_sleep_rq, // sleep request pin asserted
  input wire logic i_data_rx, // new air or serial data received
  input wire logic i_assoc_may, // association may occur
  input wire logic i_wdt_reset, // reset was by watchdog
  input wire logic i_overvolt, // input voltage too high
  input wire rmc_pkg::rmc_ev_t i_assoc_ev, // association event pulse
  output logic o_poll_tx, // send poll pulse
  output logic o_sleep_ok, // sleep allowed
  output rmc_pkg::rmc_msg_t o_status_msg // status message pulse
);
  import rmc_pkg::*;

  typedef struct packed {
    rmc_slot_t [NSLOT-1:0] slot;
    logic [31:0] ctrl;
    logic [31:0] sp;
    logic [31:0] st;
    logic [7:0] aflags;
    logic [7:0] sopt;
    logic [7:0] elvl;
    logic [3:0] be_min;
    logic [1:0] mac_mode;
    logic [15:0] fail_cnt;
    logic [7:0] acode;
    logic [31:0] rdata;
    rmc_tx_t txs;
    rmc_frame_t fr;
    logic [3:0] be;
    logic [2:0] cca_n;
    logic [1:0] tries;
    logic [TW-1:0] tcnt;
    logic [TW-1:0] wake_cnt;
    logic [TW-1:0] char_cnt;
    logic exit_poll;
    logic boot;
    logic ov_q;
    logic [15:0] lfsr;
    rmc_txres_t res;
    rmc_msg_t msg;
    logic poll;
  } rmc_st_t;

  rmc_st_t s_q, s_d;

  // count helpers
  function automatic logic [TW-1:0] dec(input logic [TW-1:0] v);
    dec = (v == '0) ? '0 : v - 1'b1;
  endfunction
  function automatic logic [TW-1:0] hold_timeout(input logic [31:0] sp);
    hold_timeout = TW'((sp << 1) + (sp >> 1)); // 2.5 x sleep period
  endfunction

  logic [2:0] mode;
  logic coord;
  logic [TW-1:0] rnd_backoff;
  logic [TW-1:0] rnd_retry;
  logic energy_clear;
  logic [7:0] new_code;
  logic [7:0] new_kind;
  logic hit;
  logic [1:0] hit_i;
  logic free_ok;
  logic [1:0] free_i;

  assign mode = s_q.ctrl[C_MODE_HI:C_MODE_LO];
  assign coord = s_q.ctrl[C_COORD];
  assign energy_clear = (i_energy <= s_q.elvl);
  assign rnd_backoff = TW'(s_q.lfsr & ((16'h0001 << s_q.be) - 16'h0001)) * BACKOFF_CYC;
  assign rnd_retry = TW'(RETRY_MIN_MS * CYC_PER_MS)
    + TW'(s_q.lfsr % 16'((RETRY_MAX_MS - RETRY_MIN_MS) * CYC_PER_MS / 16'h0100 + 16'h0001))
      * TW'(16'h0100);

  // slot lookup for the outgoing frame
  always_comb begin
    hit = 1'b0;
    hit_i = '0;
    free_ok = 1'b0;
    free_i = '0;
    for (int i = 0; i < NSLOT; i++) begin
      if (s_q.slot[i].used && s_q.slot[i].addr == s_q.fr.dest && !hit) begin
        hit = 1'b1;
        hit_i = 2'(i);
      end
      if (!s_q.slot[i].used && !free_ok) begin
        free_ok = 1'b1;
        free_i = 2'(i);
      end
    end
  end

  // association event decode
  always_comb begin
    new_code = s_q.acode;
    new_kind = 8'h00;
    case (i_assoc_ev)
      RMC_EV_COORD_UP: begin
        new_code = AC_OK;
        new_kind = ST_FORMED;
      end
      RMC_EV_ASSOC: begin
        new_code = AC_OK;
        new_kind = ST_ASSOC;
      end
      RMC_EV_PEER: new_code = AC_OK;
      RMC_EV_NO_JOIN: new_code = AC_NO_JOIN;
      RMC_EV_BEACON: new_code = AC_BEACON;
      RMC_EV_PAN_MISMATCH: new_code = AC_PAN_MISMATCH;
      RMC_EV_CH_MISMATCH: new_code = AC_CH_MISMATCH;
      RMC_EV_NO_RESP: new_code = AC_NO_RESP;
      RMC_EV_DISASSOC: begin
        new_code = AC_DISASSOC;
        new_kind = ST_DISASSOC;
      end
      RMC_EV_FORM_FAIL: new_kind = ST_DISASSOC;
      default: new_code = s_q.acode;
    endcase
  end

  // next state
  always_comb begin
    s_d = s_q;
    s_d.res = '0;
    s_d.msg = '0;
    s_d.poll = 1'b0;
    s_d.lfsr = {s_q.lfsr[14:0], s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};

    // register writes and reads
    if (i_bus.wr) begin
      case (i_bus.addr)
        A_CTRL: s_d.ctrl = i_bus.wdata;
        A_SLEEP_PERIOD: s_d.sp = i_bus.wdata;
        A_AWAKE_HOLD: s_d.st = i_bus.wdata;
        A_ASSOC_FLAGS: s_d.aflags = i_bus.wdata[7:0];
        A_SLEEP_OPT: s_d.sopt = i_bus.wdata[7:0];
        A_ENERGY_LVL: s_d.elvl = i_bus.wdata[7:0];
        A_BACKOFF_MIN: s_d.be_min = i_bus.wdata[3:0];
        A_MAC_MODE: s_d.mac_mode = i_bus.wdata[1:0];
        A_FAIL_COUNT: if (i_bus.wdata[15:0] == 16'h0000) s_d.fail_cnt = '0;
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    s_d.rdata = 32'h0000_0000;
    if (i_bus.rd) begin
      case (i_bus.addr)
        A_CTRL: s_d.rdata = s_q.ctrl;
        A_SLEEP_PERIOD: s_d.rdata = s_q.sp;
        A_AWAKE_HOLD: s_d.rdata = s_q.st;
        A_ASSOC_FLAGS: s_d.rdata = {24'h00_0000, s_q.aflags};
        A_SLEEP_OPT: s_d.rdata = {24'h00_0000, s_q.sopt};
        A_ENERGY_LVL: s_d.rdata = {24'h00_0000, s_q.elvl};
        A_BACKOFF_MIN: s_d.rdata = {28'h000_0000, s_q.be_min};
        A_MAC_MODE: s_d.rdata = {30'h0000_0000, s_q.mac_mode};
        A_STATUS: s_d.rdata = {29'h0000_0000, s_q.txs};
        A_ASSOC_CODE: s_d.rdata = {24'h00_0000, s_q.acode};
        A_FAIL_COUNT: s_d.rdata = {16'h0000, s_q.fail_cnt};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // per-address timers, poll and traffic
    for (int i = 0; i < NSLOT; i++) begin
      s_d.slot[i].awake_cnt = dec(s_q.slot[i].awake_cnt);
      s_d.slot[i].hold_cnt = dec(s_q.slot[i].hold_cnt);
      if (s_q.slot[i].used && s_q.slot[i].pending && s_q.slot[i].hold_cnt == '0) begin
        s_d.slot[i].pending = 1'b0;
      end
      if (s_q.slot[i].used && (i_poll_rx && s_q.slot[i].addr == i_poll_addr)) begin
        if (s_q.slot[i].pending) begin
          s_d.res = '{send: 1'b1, held: 1'b0, fail: 1'b0, dest: s_q.slot[i].addr};
          s_d.slot[i].pending = 1'b0;
        end
        s_d.slot[i].awake_cnt = TW'(s_q.st);
      end
      if (s_q.slot[i].used && i_traffic && s_q.slot[i].addr == i_traffic_addr
          && s_q.slot[i].awake_cnt != '0) begin
        s_d.slot[i].awake_cnt = TW'(s_q.st);
      end
      if (s_d.slot[i].used && !s_d.slot[i].pending && s_d.slot[i].awake_cnt == '0) begin
        s_d.slot[i].used = 1'b0;
      end
    end

    // transmit sequencer
    s_d.tcnt = dec(s_q.tcnt);
    case (s_q.txs)
      RMC_TX_IDLE: begin
        if (i_frame.valid) begin
          s_d.fr = i_frame;
          s_d.be = s_q.be_min;
          s_d.cca_n = '0;
          s_d.tries = '0;
          s_d.txs = RMC_TX_BACKOFF;
          s_d.tcnt = '0; // zero exponent assesses at once
          if (s_q.be_min != 4'h0) s_d.tcnt = rnd_backoff;
        end
      end
      RMC_TX_BACKOFF: if (s_q.tcnt == '0) s_d.txs = RMC_TX_ASSESS;
      RMC_TX_ASSESS: begin
        if (s_q.ov_q || i_overvolt) begin
          s_d.txs = RMC_TX_ASSESS; // overvoltage withholds sending
        end else if (energy_clear) begin
          s_d.txs = RMC_TX_SEND;
        end else if (s_q.cca_n + 3'h1 < CCA_CYCLES) begin
          s_d.cca_n = s_q.cca_n + 3'h1;
          if (s_q.be < BE_MAX) s_d.be = s_q.be + 4'h1;
          s_d.tcnt = rnd_backoff;
          s_d.txs = RMC_TX_BACKOFF;
        end else begin
          if (s_q.fail_cnt != 16'hFFFF) s_d.fail_cnt = s_q.fail_cnt + 16'h0001;
          if ((s_q.mac_mode == 2'h0 || s_q.fr.bcast || s_q.fr.retries == 3'h0)
              && s_q.tries < CCA_RETRIES) begin
            s_d.tries = s_q.tries + 2'h1;
            s_d.cca_n = '0;
            s_d.be = s_q.be_min;
            s_d.tcnt = rnd_retry;
            s_d.txs = RMC_TX_RETRY_WAIT;
          end else begin
            s_d.res = '{send: 1'b0, held: 1'b0, fail: 1'b1, dest: s_q.fr.dest};
            s_d.txs = RMC_TX_IDLE;
          end
        end
      end
      RMC_TX_RETRY_WAIT: if (s_q.tcnt == '0) s_d.txs = RMC_TX_BACKOFF;
      RMC_TX_SEND: begin
        s_d.txs = RMC_TX_IDLE;
        if (coord && s_q.sp != 32'h0000_0000 && !s_q.fr.bcast
            && !(hit && s_q.slot[hit_i].awake_cnt != '0)) begin
          // hold for a poll
          if (hit) begin
            s_d.slot[hit_i].pending = 1'b1;
            s_d.slot[hit_i].hold_cnt = hold_timeout(s_q.sp);
            s_d.res = '{send: 1'b0, held: 1'b1, fail: 1'b0, dest: s_q.fr.dest};
          end else if (free_ok) begin
            s_d.slot[free_i] = '{used: 1'b1, pending: 1'b1, addr: s_q.fr.dest,
                                 hold_cnt: hold_timeout(s_q.sp), awake_cnt: '0};
            s_d.res = '{send: 1'b0, held: 1'b1, fail: 1'b0, dest: s_q.fr.dest};
          end else begin
            s_d.res = '{send: 1'b0, held: 1'b0, fail: 1'b1, dest: s_q.fr.dest};
          end
        end else begin
          s_d.res = '{send: 1'b1, held: 1'b0, fail: 1'b0, dest: s_q.fr.dest};
          if (hit) s_d.slot[hit_i].awake_cnt = TW'(s_q.st);
        end
      end
      default: s_d.txs = RMC_TX_IDLE;
    endcase

    // wake timers and polls
    s_d.wake_cnt = dec(s_q.wake_cnt);
    s_d.char_cnt = dec(s_q.char_cnt);
    if (i_wake || i_pin_wake) begin
      if (mode == SM_CYCLIC_PIN && i_pin_wake) s_d.wake_cnt = TW'(s_q.st);
      else if (i_assoc_may) s_d.wake_cnt = TW'(ASSOC_WAKE_CYC);
      else s_d.wake_cnt = TW'(POLL_WAKE_CYC);
      s_d.char_cnt = TW'(CHAR_CYC);
      if ((mode == SM_CYCLIC || mode == SM_CYCLIC_PIN) && !s_q.sopt[O_NO_POLL]) begin
        s_d.poll = 1'b1;
      end
      if (mode == SM_PIN && i_pin_wake && s_q.aflags[F_POLL_PIN]) s_d.poll = 1'b1;
    end
    if (i_data_rx) s_d.wake_cnt = s_d.wake_cnt + TW'(s_q.st);
    if (i_exit_poll_req) s_d.exit_poll = 1'b1;
    if (s_q.exit_poll && !i_cmd_mode && i_cfg_applied) begin
      s_d.poll = 1'b1;
      s_d.exit_poll = 1'b0;
    end

    // status messages and codes
    s_d.acode = new_code;
    s_d.ov_q = i_overvolt;
    if (s_q.boot) begin
      s_d.boot = 1'b0;
      s_d.msg = '{valid: s_q.ctrl[C_FRAMED], kind: i_wdt_reset ? ST_WDT_RESET : ST_HW_RESET};
    end else if (i_overvolt && !s_q.ov_q) begin
      s_d.msg = '{valid: s_q.ctrl[C_FRAMED], kind: ST_OVERVOLT};
    end else if (i_assoc_ev inside {RMC_EV_COORD_UP, RMC_EV_ASSOC, RMC_EV_DISASSOC,
                                    RMC_EV_FORM_FAIL}) begin
      s_d.msg = '{valid: s_q.ctrl[C_FRAMED], kind: new_kind};
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
      s_q.acode <= AC_INIT;
      s_q.boot <= 1'b1;
      s_q.lfsr <= 16'hACE1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign o_rdata = s_q.rdata;
  assign o_frame_ready = (s_q.txs == RMC_TX_IDLE);
  assign o_txres = s_q.res;
  assign o_poll_tx = s_q.poll;
  assign o_status_msg = s_q.msg;
  assign o_sleep_ok = !i_cmd_mode && !i_cfg_busy
    && !(i_ser_pending && !i_rts_hold)
    && !(mode == SM_PIN && s_q.char_cnt != '0)
    && !(mode != SM_PIN && s_q.wake_cnt != '0)
    && !(mode == SM_PIN && !i_sleep_rq)
    && (s_q.txs == RMC_TX_IDLE) && !i_frame.valid && !s_q.exit_poll;
endmodule
`default_nettype wire

//--- testbench/rmc_ctrl_assertions.sv
`default_nettype none
module rmc_ctrl_assertions (
  input wire logic i_clk, // system clock
  input wire logic i_rst_b, // reset, active low
  input wire rmc_pkg::rmc_bus_t i_bus, // register strobes
  input wire logic [31:0] o_rdata, // read data
  input wire rmc_pkg::rmc_frame_t i_frame, // frame request
  input wire rmc_pkg::rmc_txres_t o_txres, // dispatch result
  input wire logic i_overvolt, // supply too high
  input wire logic i_cmd_mode, // command mode
  input wire logic i_cfg_busy, // config work
  input wire logic i_ser_pending, // serial output queued
  input wire logic i_rts_hold, // serial output held off
  input wire logic o_sleep_ok, // sleep allowed
  input wire logic o_poll_tx, // poll pulse
  input wire rmc_pkg::rmc_msg_t o_status_msg // status pulse
);
  import rmc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // sleep gating by pending work
  AST_SLEEP_CMD: assert property (i_cmd_mode |-> !o_sleep_ok)
    else $error("sleep allowed in command mode");
  AST_SLEEP_CFG: assert property (i_cfg_busy |-> !o_sleep_ok)
    else $error("sleep allowed during config work");
  AST_SLEEP_SER: assert property (i_ser_pending && !i_rts_hold |-> !o_sleep_ok)
    else $error("sleep allowed with serial output queued");
  AST_SLEEP_TX: assert property (i_frame.valid |-> !o_sleep_ok)
    else $error("sleep allowed with a frame waiting");
  // status kinds, transmit results, poll pulse and idle read data
  AST_STATUS_KIND: assert property (o_status_msg.valid |->
    o_status_msg.kind inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h0D})
    else $error("status message of unknown kind");
  AST_OVERVOLT_MUTE: assert property (i_overvolt [*3] |-> !o_txres.send)
    else $error("frame sent under overvoltage");
  AST_RESULT_ONE: assert property ($onehot0({o_txres.send, o_txres.held, o_txres.fail}))
    else $error("more than one dispatch result at once");
  AST_POLL_PULSE: assert property (o_poll_tx |=> !o_poll_tx)
    else $error("poll pulse longer than one cycle");
  AST_RDATA_IDLE: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  // main scenarios reached
  COV_SEND: cover property (o_txres.send);
  COV_HELD: cover property (o_txres.held);
  COV_POLL: cover property (o_poll_tx);
  COV_STATUS: cover property (o_status_msg.valid);
endmodule
bind rmc_ctrl rmc_ctrl_assertions i_rmc_ctrl_assertions (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_bus(i_bus), .o_rdata(o_rdata), .i_frame(i_frame), .o_txres(o_txres),
  .i_overvolt(i_overvolt), .i_cmd_mode(i_cmd_mode), .i_cfg_busy(i_cfg_busy),
  .i_ser_pending(i_ser_pending), .i_rts_hold(i_rts_hold), .o_sleep_ok(o_sleep_ok),
  .o_poll_tx(o_poll_tx), .o_status_msg(o_status_msg));
`default_nettype wire

//--- testbench/rmc_peer_model.sv
`default_nettype none
module rmc_peer_model (
  input wire logic i_clk, // system clock
  input wire logic i_poll_tx, // poll sent by the block
  output logic o_poll_rx, // poll heard from a sleeper
  output logic [15:0] o_poll_addr, // polling address
  output logic o_traffic, // air activity with an address
  output logic [15:0] o_traffic_addr, // activity address
  output logic [7:0] o_energy // channel energy
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_polls = 0;
  // quiet channel at start
  initial begin
    o_poll_rx = 1'b0;
    o_traffic = 1'b0;
    o_poll_addr = 16'h5A5A;
    o_traffic_addr = 16'hA5A5;
    o_energy = 8'h10;
  end
  // polls the block sends to its coordinator
  always @(posedge i_clk) begin
    if (i_poll_tx === 1'b1) n_polls <= n_polls + 1;
  end
  // one poll or traffic pulse; address lines carry junk once released
  task automatic hit(input logic t, input logic [15:0] a);
    @(posedge i_clk);
    o_traffic <= t;
    o_poll_rx <= !t;
    o_poll_addr <= a;
    o_traffic_addr <= a;
    @(posedge i_clk);
    o_traffic <= 1'b0;
    o_poll_rx <= 1'b0;
    o_poll_addr <= ~a;
    o_traffic_addr <= ~a;
  endtask
  // channel energy changes after an edge
  task automatic set_energy(input logic [7:0] e);
    @(posedge i_clk);
    o_energy <= e;
  endtask
endmodule
`default_nettype wire

//--- testbench/test_radio_mac_poll_sleep_cca_control.sv
`default_nettype none
module test_radio_mac_poll_sleep_cca_control;
  timeunit 1ns;
  timeprecision 1ns;
  import rmc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  rmc_bus_t i_bus = '0;
  rmc_frame_t i_frame = '0;
  rmc_ev_t assoc_ev = RMC_EV_NONE;
  logic [3:0] pulses = 4'h0;
  logic [4:0] gates = 5'h00;
  logic overvolt = 1'b0;
  logic [31:0] o_rdata;
  logic o_frame_ready, o_poll_tx, o_sleep_ok, poll_rx, traffic;
  logic [15:0] poll_addr, traffic_addr;
  logic [7:0] energy;
  rmc_txres_t o_txres;
  rmc_msg_t o_status_msg;
  int n_errors = 0;
  int n_compared = 0;
  int polls_seen = 0;
  int i;
  int k;
  rmc_ev_t evs [10] = '{RMC_EV_COORD_UP, RMC_EV_NO_JOIN, RMC_EV_BEACON, RMC_EV_PAN_MISMATCH,
    RMC_EV_CH_MISMATCH, RMC_EV_NO_RESP, RMC_EV_DISASSOC, RMC_EV_ASSOC, RMC_EV_PEER,
    RMC_EV_FORM_FAIL};
  logic [7:0] codes [10] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0C, 8'h13, 8'h00, 8'h00,
    8'h00};
  logic [7:0] kinds [10] = '{8'h06, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h02, 8'hFF,
    8'h03};
  // 20 MHz clock
  always #25 i_clk = ~i_clk;
  rmc_ctrl i_rmc_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_frame(i_frame), .o_frame_ready(o_frame_ready), .i_poll_rx(poll_rx),
    .i_poll_addr(poll_addr), .i_traffic(traffic), .i_traffic_addr(traffic_addr),
    .o_txres(o_txres), .i_energy(energy), .i_wake(pulses[0]), .i_pin_wake(pulses[1]),
    .i_cmd_mode(gates[0]), .i_cfg_busy(gates[1]), .i_cfg_applied(pulses[2]),
    .i_exit_poll_req(pulses[3]), .i_ser_pending(gates[2]), .i_rts_hold(gates[3]),
    .i_sleep_rq(gates[4]), .i_data_rx(1'b0), .i_assoc_may(1'b0), .i_wdt_reset(1'b0),
    .i_overvolt(overvolt), .i_assoc_ev(assoc_ev), .o_poll_tx(o_poll_tx),
    .o_sleep_ok(o_sleep_ok), .o_status_msg(o_status_msg));
  rmc_peer_model i_rmc_peer_model (.i_clk(i_clk), .i_poll_tx(o_poll_tx), .o_poll_rx(poll_rx),
    .o_poll_addr(poll_addr), .o_traffic(traffic), .o_traffic_addr(traffic_addr),
    .o_energy(energy));
  // verdict and end of run
  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask
  // register write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_bus.wr <= 1'b1;
    i_bus.addr <= a;
    i_bus.wdata <= d;
    @(posedge i_clk);
    i_bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge i_clk);
    i_bus.rd <= 1'b1;
    i_bus.addr <= a;
    @(posedge i_clk);
    i_bus.rd <= 1'b0;
    #1 chk(o_rdata, exp, what);
  endtask
  // wait for a dispatch result as {send, held, fail}
  task automatic res(input int lim, input logic [2:0] exp, input string what);
    logic [2:0] got;
    got = 3'h0;
    for (k = 0; k < lim && got === 3'h0; k++) begin
      #1 got = {o_txres.send, o_txres.held, o_txres.fail};
      if (got === 3'h0) @(posedge i_clk);
    end
    chk({29'h0, got}, {29'h0, exp}, what);
    if (got === 3'h0 && exp !== 3'h0) tally_and_finish();
  endtask
  // hand one frame over, held until taken
  task automatic send(input logic [15:0] d, input int lim, input logic [2:0] exp, input string w);
    @(posedge i_clk);
    i_frame <= '{valid: 1'b1, dest: d, bcast: 1'b0, retries: 3'h0};
    k = 0;
    do @(posedge i_clk); while (o_frame_ready !== 1'b1 && ++k < 100);
    i_frame.valid <= 1'b0;
    if (k == 100) begin
      n_errors++;
      tally_and_finish();
    end
    res(lim, exp, w);
  endtask
  // wake or config pulses, then count polls on air
  task automatic kick(input logic [3:0] m, input int exp, input string what);
    @(posedge i_clk);
    pulses <= m;
    @(posedge i_clk);
    pulses <= 4'h0;
    repeat (20) @(posedge i_clk);
    chk(i_rmc_peer_model.n_polls - polls_seen, exp, what);
    polls_seen = i_rmc_peer_model.n_polls;
  endtask
  // hang guard
  initial begin
    repeat (95000) @(posedge i_clk);
    n_errors++;
    $display("[ERR] %0t run did not complete", $time);
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(A_ASSOC_CODE, 32'h0000_00FF, "initial code");
    rd(A_FAIL_COUNT, 32'h0000_0000, "fail count");
    rd(8'h3C, 32'h0000_0000, "unmapped read");
    wr(A_CTRL, 32'h0000_0004);
    gates <= 5'h1C;
    @(posedge i_clk);
    #1 chk({31'h0, o_sleep_ok}, 32'h0000_0001, "sleep allowed");
    @(posedge i_clk);
    gates <= 5'h0C;
    @(posedge i_clk);
    #1 chk({31'h0, o_sleep_ok}, 32'h0000_0000, "no sleep request");
    wr(A_CTRL, 32'h0000_0002);
    for (i = 0; i < 10; i++) begin
      @(posedge i_clk);
      assoc_ev <= evs[i];
      @(posedge i_clk);
      assoc_ev <= RMC_EV_NONE;
      #1;
      for (k = 0; k < 8 && o_status_msg.valid !== 1'b1; k++) @(posedge i_clk) #1;
      if (kinds[i] != 8'hFF) chk({23'h0, o_status_msg}, {23'h0, 1'b1, kinds[i]}, "status");
      rd(A_ASSOC_CODE, {24'h0, codes[i]}, "assoc code");
    end
    // coordinator: direct, held, poll, awake hold, timeout
    wr(A_ENERGY_LVL, 32'h0000_0020);
    wr(A_CTRL, 32'h0000_0001);
    send(16'h0042, 5, 3'h4, "direct, no sleep period");
    wr(A_SLEEP_PERIOD, 32'h0000_03E8);
    wr(A_AWAKE_HOLD, 32'h0000_00C8);
    send(16'h0042, 100, 3'h2, "held");
    i_rmc_peer_model.hit(1'b0, 16'h0042);
    res(100, 3'h4, "sent on poll");
    send(16'h0042, 100, 3'h4, "direct while awake");
    repeat (150) @(posedge i_clk);
    i_rmc_peer_model.hit(1'b1, 16'h0042);
    repeat (150) @(posedge i_clk);
    send(16'h0042, 100, 3'h4, "traffic restarts hold");
    repeat (250) @(posedge i_clk);
    send(16'h0042, 100, 3'h2, "held after hold");
    repeat (2600) @(posedge i_clk);
    i_rmc_peer_model.hit(1'b0, 16'h0042);
    res(60, 3'h0, "dropped after timeout");
    // energy above level, then at level, then overvoltage
    wr(A_CTRL, 32'h0000_0000);
    i_rmc_peer_model.set_energy(8'h21);
    send(16'h0007, 6, 3'h0, "busy channel");
    i_rmc_peer_model.set_energy(8'h20);
    res(50000, 3'h4, "clear channel");
    @(posedge i_clk);
    overvolt <= 1'b1;
    send(16'h0007, 40, 3'h0, "overvoltage");
    overvolt <= 1'b0;
    res(100, 3'h4, "after overvoltage");
    // polls on wake and on command mode exit
    wr(A_CTRL, 32'h0000_0010);
    kick(4'h1, 1, "cyclic wake poll");
    wr(A_SLEEP_OPT, 32'h0000_0001);
    kick(4'h1, 0, "cyclic poll off");
    wr(A_CTRL, 32'h0000_0004);
    kick(4'h2, 0, "pin wake no poll");
    wr(A_ASSOC_FLAGS, 32'h0000_0008);
    kick(4'h2, 1, "pin wake poll");
    gates <= 5'h01;
    kick(4'h8, 0, "exit poll in command mode");
    kick(4'h4, 0, "apply in command mode");
    gates <= 5'h00;
    kick(4'h0, 0, "exit poll before apply");
    kick(4'h4, 1, "exit poll after apply");
    // sleep blocked by command mode, config work and queued serial output
    for (i = 0; i < 3; i++) begin
      @(posedge i_clk);
      gates <= 5'h01 << i;
      @(posedge i_clk);
      #1 chk({31'h0, o_sleep_ok}, 32'h0000_0000, "sleep gated");
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
